// ==== design/asq_pkg.sv ====
package asq_pkg;
    // System clock rate and derived timing.
    localparam int CLK_HZ = 20_000_000;
    localparam int POR_CYCLES = 65536;
    localparam int RESET_HOLD_US_X10 = 6;
    localparam int RESET_HOLD_CYCLES =
        (RESET_HOLD_US_X10 * (CLK_HZ / 1000) + 9) / 10;
    localparam int SEL_WRITE_US = 513;
    localparam int SEL_WRITE_CYCLES = SEL_WRITE_US * (CLK_HZ / 1_000_000);
    localparam int CONV_CYCLES = SEL_WRITE_CYCLES;
    // Opcodes.
    localparam logic [7:0] OP_WAKE = 8'h00;
    localparam logic [7:0] OP_SLEEP = 8'h02;
    localparam logic [7:0] OP_SYNC = 8'h04;
    localparam logic [7:0] OP_RESET = 8'h06;
    localparam logic [7:0] OP_RDATA = 8'h12;
    localparam logic [7:0] OP_CONT_READ = 8'h14;
    localparam logic [7:0] OP_STOP_CONT = 8'h16;
    localparam logic [3:0] OP_REG_READ_HI = 4'h2;
    localparam logic [3:0] OP_REG_WRITE_HI = 4'h4;
    localparam int NUM_REGS = 16;
    localparam logic [3:0] CHAN_REG_ADDR = 4'h0;
    localparam logic [3:0] GAIN_REG_ADDR = 4'h3;
    localparam int RESULT_BITS = 16;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    typedef enum logic [2:0] {
        ASQ_OPC, ASQ_CNT, ASQ_WDATA, ASQ_RDATA, ASQ_SHIFT, ASQ_IGNORE
    } asq_frame_t;
endpackage

// ==== design/asq_sequencer.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Hold internal reset 2^16 clocks, ignore commands.
// - Start pin high enables conversions.
// - SPI mode 1: launch rising, sample falling.
// - Opcode 06h resets; host waits 0.6 ms.
// - Opcode 16h leaves continuous read mode.
// - Write frame: opcode, count-1, data bytes.
// - Read frame: opcode, count-1, data shifted out.
// - Opcode 04h restarts a fresh conversion.
// - Chip select high resets the frame logic.
// - Ready output falls on new result.
// - Host may poll after one data period.
// - Opcode 12h then 16 clocks shift result.
// - Opcode 02h halts conversions, powers down.
// - Continuous read is the default after reset.
// - Write accepted while result shifts out.
// - Ready falls 0.513 ms after channel write.
// - First four registers set up the block.
// - Start low finishes conversion then powers down.
// - Last result readable during power-down.
module asq_sequencer
    import asq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic start,
    input wire logic [15:0] conv_data,
    output logic serial_out_ready_n,
    output logic serial_out_oe,
    output logic result_ready_n,
    output logic continuous_read_mode,
    output logic powered_down,
    output logic in_reset,
    output logic [7:0] channel_select_reg,
    output logic [7:0] gain_rate_reg
);
    // Link domain: frame decoder on sclk, async cleared by cs_n high.
    logic [2:0] bit_cnt_r;
    logic [7:0] sh_in_r;
    logic [7:0] out_sh_r;
    logic [15:0] res_sh_r;
    logic res_mode_r;
    logic out_bit_r;
    asq_frame_t frame_r;
    logic [3:0] addr_r;
    logic [3:0] cnt_r;
    logic first_r;
    logic [4:0] res_cnt_r;
    // Opcode of the open frame; it only steers the frame decoder.
    logic [7:0] op_r;
    // Link-domain events handed across to the system clock. These flops are
    // cleared by the system reset only, never by chip select: a frame that
    // ends must neither fake a toggle nor change a word still in flight.
    logic cmd_tgl_r;
    logic [7:0] cmd_r;
    // Register writes are staged here and copied over once the frame ends.
    // The link clock may run faster than the system clock, so a byte that
    // is handed across on its own could be overwritten by the next one.
    logic [15:0] wr_mask_r;
    logic [7:0] stage_r [NUM_REGS];
    logic frame_start;
    logic cmd_done;
    logic wr_done;

    logic [7:0] regs_r [NUM_REGS];
    logic [7:0] rd_snap_r;
    logic [15:0] result_r;
    logic cont_r;
    logic link_reset;

    logic [7:0] byte_in;
    assign byte_in = {sh_in_r[6:0], din};
    assign link_reset = cs_n;

    function automatic logic is_reg_op(
        input logic [7:0] b,
        input logic [3:0] hi
    );
        return b[7:4] == hi;
    endfunction

    // Register read and write opcodes carry the start address in the low
    // nibble; every other byte in opcode position is a plain command.
    function automatic logic is_addr_op(input logic [7:0] b);
        return is_reg_op(b, OP_REG_WRITE_HI) || is_reg_op(b, OP_REG_READ_HI);
    endfunction

    // A byte completes on the eighth falling edge of its group.
    assign frame_start = first_r && (bit_cnt_r == 3'h0);
    assign cmd_done = (bit_cnt_r == 3'h7) && (frame_r == ASQ_OPC) &&
        !is_addr_op(byte_in);
    assign wr_done = (bit_cnt_r == 3'h7) && (frame_r == ASQ_WDATA);

    // Input sampled on the falling edge.
    always_ff @(negedge sclk or posedge link_reset) begin
        if (link_reset) begin
            bit_cnt_r <= 3'h0;
            sh_in_r <= 8'h00;
            frame_r <= ASQ_OPC;
            op_r <= 8'h00;
            addr_r <= 4'h0;
            cnt_r <= 4'h0;
            first_r <= 1'b1;
            res_cnt_r <= 5'h00;
        end else begin
            sh_in_r <= byte_in;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (res_cnt_r != 5'h00) begin
                res_cnt_r <= res_cnt_r - 5'h01;
            end
            if (bit_cnt_r == 3'h7) begin
                first_r <= 1'b0;
                case (frame_r)
                    ASQ_OPC: begin
                        op_r <= byte_in;
                        if (is_addr_op(byte_in)) begin
                            addr_r <= byte_in[3:0];
                            frame_r <= ASQ_CNT;
                        end else if (byte_in == OP_RDATA) begin
                            frame_r <= ASQ_SHIFT;
                            res_cnt_r <= 5'(RESULT_BITS);
                        end
                    end
                    ASQ_CNT: begin
                        cnt_r <= byte_in[3:0];
                        frame_r <= is_reg_op(op_r, OP_REG_WRITE_HI) ?
                            ASQ_WDATA : ASQ_RDATA;
                    end
                    ASQ_WDATA: begin
                        addr_r <= addr_r + 4'h1;
                        cnt_r <= cnt_r - 4'h1;
                        if (cnt_r == 4'h0) begin
                            frame_r <= ASQ_IGNORE;
                        end
                    end
                    ASQ_RDATA: begin
                        addr_r <= addr_r + 4'h1;
                        cnt_r <= cnt_r - 4'h1;
                        if (cnt_r == 4'h0) begin
                            frame_r <= ASQ_IGNORE;
                        end
                    end
                    ASQ_SHIFT: begin
                        if (res_cnt_r <= 5'h01) begin
                            frame_r <= ASQ_OPC;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Handoff flops. The system reset clears them asynchronously, which is
    // safe because the link clock does not run while the system is held in
    // reset. Two plain commands in one frame need about three system clocks
    // between them, or the first one may be missed.
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            cmd_tgl_r <= 1'b0;
            cmd_r <= 8'h00;
            wr_mask_r <= 16'h0000;
        end else begin
            if (cmd_done) begin
                cmd_r <= byte_in;
                cmd_tgl_r <= ~cmd_tgl_r;
            end
            if (frame_start) begin
                wr_mask_r <= 16'h0000;
            end else if (wr_done) begin
                wr_mask_r[addr_r] <= 1'b1;
            end
        end
    end

    // Staging copy of written bytes. Only entries marked in the mask are
    // ever read, so it needs no reset.
    always_ff @(negedge sclk) begin
        if (wr_done) begin
            stage_r[addr_r] <= byte_in;
        end
    end

    // Read data for the pending register, launched from register copies.
    // The register array is read across domains; it is stable during reads
    // because writes only come from this same frame stream.
    logic [7:0] rd_byte;
    assign rd_byte = regs_r[addr_r];

    // Output launched on the rising edge.
    always_ff @(posedge sclk or posedge link_reset) begin
        if (link_reset) begin
            res_sh_r <= 16'h0000;
            out_sh_r <= 8'h00;
            res_mode_r <= 1'b0;
            out_bit_r <= 1'b1;
        end else if (bit_cnt_r == 3'h0 &&
                     (first_r || frame_r == ASQ_SHIFT) && !res_mode_r &&
                     (res_cnt_r != 5'h00 || (first_r && cont_r))) begin
            // First edge of a readout: result shifts out MSB first.
            res_sh_r <= {result_r[14:0], 1'b0};
            out_bit_r <= result_r[15];
            res_mode_r <= 1'b1;
        end else if (res_mode_r) begin
            out_bit_r <= res_sh_r[15];
            res_sh_r <= {res_sh_r[14:0], 1'b0};
        end else if (bit_cnt_r == 3'h0 && frame_r == ASQ_RDATA) begin
            out_bit_r <= rd_byte[7];
            out_sh_r <= {rd_byte[6:0], 1'b0};
        end else begin
            out_bit_r <= out_sh_r[7];
            out_sh_r <= {out_sh_r[6:0], 1'b0};
        end
    end

    // System domain.
    logic [2:0] cmd_sync_r;
    logic cs_seen_r;
    logic [1:0] cs_sync_r, start_sync_r;
    logic [16:0] por_cnt_r;
    logic [15:0] hold_cnt_r;
    logic [15:0] conv_cnt_r;
    logic conv_run_r, pd_r, ready_n_r, stop_pending_r;
    logic wr_evt, cmd_evt;

    // Staged writes land once chip select is seen high again; the mask is
    // stable then, as no link clock runs between frames. A host must leave
    // chip select high for a few system clocks between frames.
    assign wr_evt = cs_sync_r[1] && !cs_seen_r && (wr_mask_r != 16'h0000);
    assign cmd_evt = cmd_sync_r[2] ^ cmd_sync_r[1];
    assign in_reset = (por_cnt_r != 17'h00000) || (hold_cnt_r != 16'h0000);

    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_sync_r <= 3'h0;
            cs_sync_r <= 2'h3;
            cs_seen_r <= 1'b1;
            start_sync_r <= 2'h0;
        end else begin
            cmd_sync_r <= {cmd_sync_r[1:0], cmd_tgl_r};
            cs_sync_r <= {cs_sync_r[0], cs_n};
            cs_seen_r <= cs_sync_r[1];
            start_sync_r <= {start_sync_r[0], start};
        end
    end

    // Power-on hold.
    always_ff @(posedge mclk) begin
        if (rst) begin
            por_cnt_r <= 17'(POR_CYCLES);
        end else if (por_cnt_r != 17'h00000) begin
            por_cnt_r <= por_cnt_r - 17'h00001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || (!in_reset && cmd_evt && cmd_r == OP_RESET)) begin
            cont_r <= 1'b1;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= REG_RESET_VAL;
            end
            hold_cnt_r <= rst ? 16'h0000 : 16'(RESET_HOLD_CYCLES);
        end else begin
            if (hold_cnt_r != 16'h0000) begin
                hold_cnt_r <= hold_cnt_r - 16'h0001;
            end
            if (!in_reset && cmd_evt) begin
                if (cmd_r == OP_STOP_CONT) begin
                    cont_r <= 1'b0;
                end else if (cmd_r == OP_CONT_READ) begin
                    cont_r <= 1'b1;
                end
            end
            // A write made during a readout lands at the end of that frame.
            if (!in_reset && wr_evt) begin
                for (int i = 0; i < NUM_REGS; i++) begin
                    if (wr_mask_r[i]) begin
                        regs_r[i] <= stage_r[i];
                    end
                end
            end
        end
    end

    // Conversion timer: any config write, sync or wake restarts it.
    always_ff @(posedge mclk) begin
        if (rst || in_reset) begin
            conv_cnt_r <= 16'(CONV_CYCLES);
            conv_run_r <= 1'b0;
            pd_r <= 1'b0;
            ready_n_r <= 1'b1;
            stop_pending_r <= 1'b0;
            result_r <= 16'h0000;
        end else begin
            if (!cs_sync_r[1]) begin
                ready_n_r <= 1'b1;
            end
            if (!start_sync_r[1] && conv_run_r) begin
                stop_pending_r <= 1'b1;
            end
            if (cmd_evt && cmd_r == OP_SLEEP) begin
                conv_run_r <= 1'b0;
                pd_r <= 1'b1;
            end else if ((cmd_evt && (cmd_r == OP_SYNC || cmd_r == OP_WAKE))
                         || wr_evt) begin
                conv_cnt_r <= 16'(CONV_CYCLES);
                conv_run_r <= start_sync_r[1] || (cmd_evt && cmd_r == OP_SYNC);
                pd_r <= 1'b0;
                stop_pending_r <= 1'b0;
            end else if (start_sync_r[1] && !conv_run_r && !pd_r) begin
                conv_run_r <= 1'b1;
                conv_cnt_r <= 16'(CONV_CYCLES);
            end else if (conv_run_r) begin
                if (conv_cnt_r == 16'h0001) begin
                    // Result frozen while a frame is open.
                    if (cs_sync_r[1]) begin
                        result_r <= conv_data;
                    end
                    ready_n_r <= 1'b0;
                    conv_cnt_r <= 16'(CONV_CYCLES);
                    if (stop_pending_r || !start_sync_r[1]) begin
                        conv_run_r <= 1'b0;
                        pd_r <= 1'b1;
                    end
                end else begin
                    conv_cnt_r <= conv_cnt_r - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_snap_r <= 8'h00;
        end else begin
            rd_snap_r <= regs_r[CHAN_REG_ADDR];
        end
    end

    assign channel_select_reg = rd_snap_r;
    assign gain_rate_reg = regs_r[GAIN_REG_ADDR];
    assign result_ready_n = ready_n_r;
    assign powered_down = pd_r;
    assign continuous_read_mode = cont_r;
    // Line shows ready when idle, data while selected.
    assign serial_out_ready_n = cs_n ? ready_n_r : out_bit_r;
    assign serial_out_oe = !cs_n;
endmodule // asq_sequencer

// ==== dv/asq_sequencer_sva.sv ====
`timescale 1ns/1ps
module asq_sequencer_sva
    import asq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic start,
    input wire logic serial_out_ready_n,
    input wire logic serial_out_oe,
    input wire logic result_ready_n,
    input wire logic continuous_read_mode,
    input wire logic powered_down,
    input wire logic in_reset,
    input wire logic [7:0] channel_select_reg
);
    logic [16:0] up_r;
    logic [16:0] since_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Both counters saturate so that a long idle stretch cannot wrap them.
    always_ff @(posedge mclk) begin
        if (rst) up_r <= '0;
        else if (!(&up_r)) up_r <= up_r + 17'h1;
    end
    always_ff @(posedge mclk) begin
        if (rst || $fell(result_ready_n)) since_r <= '0;
        else if (!(&since_r)) since_r <= since_r + 17'h1;
    end
    // Chip select passes a synchroniser, so only settled levels are judged.
    sequence idle4;
        cs_n [*4];
    endsequence
    sequence sel3;
        !cs_n [*3];
    endsequence
    a_oe_frame: assert property (sel3 |-> serial_out_oe)
        else $error("output enable low in frame");
    a_oe_idle: assert property (idle4 |-> !serial_out_oe)
        else $error("output enable high while idle");
    a_copy_idle: assert property (
        idle4 ##0 $stable(result_ready_n) |->
        serial_out_ready_n == result_ready_n)
        else $error("idle line is not the ready copy");
    a_hold_por: assert property (up_r < 17'd65534 |-> in_reset)
        else $error("power-on hold too short");
    a_regs_frozen: assert property (
        in_reset && $past(in_reset, 3) |-> $stable(channel_select_reg))
        else $error("register changed during hold");
    a_mode_default: assert property (
        $fell(rst) |-> continuous_read_mode)
        else $error("continuous mode not default");
    a_ready_hold: assert property (
        idle4 ##0 !result_ready_n |=> !result_ready_n)
        else $error("ready released while deselected");
    a_conv_gap: assert property (
        $fell(result_ready_n) |-> since_r >= 17'(CONV_CYCLES - 8))
        else $error("results closer than one period");
    a_pd_ready: assert property (
        $rose(powered_down) && !start && !in_reset |-> !result_ready_n)
        else $error("power-down before result ready");
endmodule // asq_sequencer_sva

bind asq_sequencer asq_sequencer_sva i_asq_sequencer_sva (
    .mclk, .rst, .cs_n, .start, .serial_out_ready_n, .serial_out_oe,
    .result_ready_n, .continuous_read_mode, .powered_down, .in_reset,
    .channel_select_reg
);

// ==== dv/asq_host.sv ====
`timescale 1ns/1ps
module asq_host (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic serial_out_ready_n
);
    logic [47:0] rx_r;
    event got;
    initial {sclk, cs_n, din} = 3'b010;
    // The clock runs only inside a frame and rests low between frames.
    task automatic frame(logic [47:0] tx, int n);
        rx_r = '0;
        cs_n = 0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1;
            din = tx[i];
            #7.5;
            sclk = 0;
            rx_r = {rx_r[46:0], serial_out_ready_n};
            #7.5;
        end
        #20;
        cs_n = 1;
        din = ~din;
        ->got;
    endtask
endmodule // asq_host

// ==== dv/test_adc_spi_command_sequencer.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
$display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_adc_spi_command_sequencer
    import asq_pkg::*;
;
    logic mclk = 0, rst = 1, start = 0;
    logic [15:0] conv_data = '0;
    logic [15:0] d1;
    logic sclk, cs_n, din, serial_out_ready_n, serial_out_oe;
    logic result_ready_n, continuous_read_mode, powered_down, in_reset;
    logic [7:0] channel_select_reg, gain_rate_reg;
    logic [31:0] seed = 32'h0ebb7167;
    logic [95:0] exp_q[$];
    int errors = 0, n_compared = 0, cyc = 0, c;
    always #25 mclk = ~mclk;
    asq_sequencer i_asq_sequencer (.mclk, .rst, .sclk, .cs_n, .din,
        .start, .conv_data, .serial_out_ready_n, .serial_out_oe,
        .result_ready_n, .continuous_read_mode, .powered_down,
        .in_reset, .channel_select_reg, .gain_rate_reg);
    asq_host i_asq_host (.sclk, .cs_n, .din, .serial_out_ready_n);
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic xfer(logic [47:0] tx, int n, logic [47:0] e,
                        logic [47:0] m);
        exp_q.push_back({e, m});
        i_asq_host.frame(tx, n);
        repeat (8) @(negedge mclk);
    endtask
    task automatic wait_rdy();
        c = 0;
        while (result_ready_n !== 1'b0 && c < 11000) begin
            @(negedge mclk);
            c++;
        end
    endtask
    always @(i_asq_host.got) begin
        logic [95:0] e;
        e = exp_q.pop_front();
        `CHK(i_asq_host.rx_r & e[47:0], e[95:48])
    end
    // The ceiling sits just above the power-on hold, the reset hold and
    // two conversions.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 100000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(negedge mclk);
        rst = 0;
        xfer(24'h40005a, 24, 0, 0);
        `CHK(channel_select_reg, 8'h00)
        `CHK(continuous_read_mode, 1'b1)
        while (in_reset !== 1'b0 && cyc < 70000) @(negedge mclk);
        `CHK(cyc >= 65546 && cyc <= 65552, 1'b1)
        $display("test done: power-on hold");
        start = 1;
        xfer(8'h06, 8, 0, 0);
        repeat (12010) @(negedge mclk);
        xfer(8'h16, 8, 0, 0);
        `CHK(continuous_read_mode, 1'b0)
        xfer(16'h4000, 16, 0, 0);
        xfer(48'h400301000342, 48, 0, 0);
        `CHK(channel_select_reg, 8'h01)
        `CHK(gain_rate_reg, 8'h42)
        xfer(48'h200300000000, 48, 48'h01000342, 48'hffffffff);
        $display("test done: register access");
        seed = lfsr(seed);
        conv_data = seed[15:0];
        d1 = seed[15:0];
        xfer(8'h14, 8, 0, 0);
        xfer(8'h04, 8, 0, 0);
        wait_rdy();
        `CHK(c > CONV_CYCLES - 30 && c < CONV_CYCLES + 30, 1'b1)
        seed = lfsr(seed);
        conv_data = seed[15:0];
        xfer(24'h400002, 24, {d1, 8'h00}, 48'hffff00);
        start = 0;
        `CHK(channel_select_reg, 8'h02)
        wait_rdy();
        `CHK(c > CONV_CYCLES - 30 && c < CONV_CYCLES + 30, 1'b1)
        repeat (4) @(negedge mclk);
        `CHK(powered_down, 1'b1)
        $display("test done: channel switch");
        xfer(16'hffff, 16, seed[15:0], 48'hffff);
        xfer(8'h16, 8, 0, 0);
        xfer(24'h12ffff, 24, seed[15:0], 48'hffff);
        start = 1;
        xfer(8'h04, 8, 0, 0);
        `CHK(powered_down, 1'b0)
        xfer(8'h02, 8, 0, 0);
        `CHK(powered_down, 1'b1)
        $display("test done: power-down readout");
        close_out();
    end
endmodule // test_adc_spi_command_sequencer
